// *** tb/testbench.sv ***
// Self-checking bench for the synchronous slave serial port
`timescale 1ns/1ps
`include "uss_regs.svh"

module testbench;
	import uss_pkg::*;
	logic            clk_in = 1'b0;  // System clock
	logic            sys_rst_in;     // Synchronous reset
	uss_bus_req_type req;            // Register request
	logic [7:0]      rdata;          // Register read data
	logic [7:0]      rv;             // Last value read
	logic            irq_out;        // Interrupt level
	logic            lclk;           // Link clock from the master
	logic            m_d;            // Master data line
	logic            d_out;          // Slave data value
	logic            d_oe;           // Slave drives the pin
	logic [8:0]      rx;             // Bits caught by the master
	int              n_errors = 0;   // Mismatches
	int              n_compared = 0; // Comparisons made
	int              cyc = 0;        // Cycles run
	wire             pin = d_oe ? d_out : m_d; // Resolved data pin

	uss_top dut (
		.clk_in(clk_in), .sys_rst_in(sys_rst_in), .bus_req_in(req), .bus_rdata_out(rdata),
		.link_clk_in(lclk), .link_data_in(pin), .link_data_out(d_out),
		.link_data_oe_out(d_oe), .irq_out(irq_out)
	);
	uss_master_model m (.link_clk_out(lclk), .data_out(m_d), .data_in(pin));

	// 50 MHz system clock
	always #10 clk_in = ~clk_in;

	// Hang guard: under a thousand cycles are expected, so this is generous
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			wrap_up();
		end
	end

	task automatic wrap_up;
		if (n_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in) req <= {1'b1, 1'b0, a, d};
		@(posedge clk_in) req <= '0;
	endtask

	// One-cycle read strobe; data stand only in the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge clk_in) req <= {1'b0, 1'b1, a, 8'h00};
		@(posedge clk_in) req <= '0;
		#1 rv = rdata;
	endtask

	// Bounded wait for the interrupt level
	task automatic wait_irq;
		for (int i = 0; i < 300 && irq_out !== 1'b1; i++)
			@(posedge clk_in);
		chk("irq", irq_out, 1'b1);
	endtask

	// Reset state of every register, unmapped address too; read-only flags masked
	task automatic t_reset;
		logic [7:0] offs [6] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h20};
		rd(`USS_OFF_TXCTL);
		chk("txctl", rv & 8'hF9, `USS_TXCTL_RST);
		foreach (offs[i]) begin
			rd(offs[i]);
			chk("reset_reg", rv, 8'h00);
		end
		chk("oe", d_oe, 1'b0);
	endtask

	// Nine-bit receive, single receive bit set but ignored, status before data
	task automatic t_rx;
		wr(`USS_OFF_MASK, 8'h02);
		wr(`USS_OFF_TXCTL, 8'h10); // Sync, slave clock
		wr(`USS_OFF_RXCTL, 8'hF0); // Port, nine-bit, continuous
		m.frame(9'h1A5, 9, rx);
		wait_irq();
		rd(`USS_OFF_RXCTL);
		chk("rx_status", rv, 8'hF1);
		rd(`USS_OFF_RXBUF);
		chk("rx_data", rv, 8'hA5);
		repeat (2) @(posedge clk_in);
		chk("irq_clear", irq_out, 1'b0);
	endtask

	// Second word while first unread: overrun kept until continuous receive drops
	task automatic t_ovr;
		wr(`USS_OFF_RXCTL, 8'h90);
		m.frame(9'h03C, 8, rx);
		m.frame(9'h0C3, 8, rx);
		rd(`USS_OFF_RXCTL);
		chk("overrun", rv & 8'hFE, 8'h92);
		rd(`USS_OFF_RXBUF);
		chk("kept", rv, 8'h3C);
		wr(`USS_OFF_RXCTL, 8'h80);
		rd(`USS_OFF_RXCTL);
		chk("err_clr", rv & 8'hFE, 8'h80);
	endtask

	// Half a word, then abort by port enable and by continuous receive
	task automatic t_abort;
		logic [7:0] stops [2] = '{8'h00, 8'h80};
		foreach (stops[i]) begin
			wr(`USS_OFF_RXCTL, 8'h90);
			m.frame(9'h0FF, 4, rx);
			wr(`USS_OFF_RXCTL, stops[i]);
			wr(`USS_OFF_RXCTL, 8'h90);
			m.frame(9'h05A, 8, rx);
			wait_irq();
			rd(`USS_OFF_RXBUF);
			chk("abort", rv, 8'h5A);
		end
	endtask

	// Clock select set: link edges must be ignored
	task automatic t_clksel;
		wr(`USS_OFF_TXCTL, 8'h90);
		m.frame(9'h077, 8, rx);
		repeat (10) @(posedge clk_in);
		rd(`USS_OFF_STAT);
		chk("master_idle", rv, 8'h00);
	endtask

	// Double-buffered transmit, then a nine-bit word, then masking
	task automatic t_tx;
		wr(`USS_OFF_RXCTL, 8'h80); // Port on, continuous receive off
		wr(`USS_OFF_TXCTL, 8'h10);
		wr(`USS_OFF_MASK, 8'h01);
		wr(`USS_OFF_STAT, 8'h03);
		wr(`USS_OFF_TXBUF, 8'h96); // Data before enable
		wr(`USS_OFF_TXCTL, 8'h30);
		repeat (4) @(posedge clk_in);
		chk("first_bit", pin, 1'b0);
		wr(`USS_OFF_TXBUF, 8'h4B);
		rd(`USS_OFF_STAT);
		chk("tx_flag", rv, 8'h00);
		rd(`USS_OFF_TXCTL);
		chk("buf_full", rv[1], 1'b0);
		chk("irq_low", irq_out, 1'b0);
		m.frame(9'h000, 8, rx);
		chk("word1", rx, 9'h096);
		wait_irq();
		m.frame(9'h000, 8, rx);
		chk("word2", rx, 9'h04B);
		wr(`USS_OFF_TXCTL, 8'h71);
		wr(`USS_OFF_TXBUF, 8'hE1);
		m.frame(9'h000, 9, rx);
		chk("word9", rx, 9'h1E1);
		wr(`USS_OFF_MASK, 8'h00);
		repeat (2) @(posedge clk_in);
		chk("masked", irq_out, 1'b0);
		rd(`USS_OFF_STAT);
		chk("sticky", rv, 8'h01);
		wr(`USS_OFF_STAT, 8'h01);
		rd(`USS_OFF_STAT);
		chk("w1c", rv, 8'h00);
	endtask

	// Reset, then the scenarios in turn
	initial begin
		req        = '0;
		sys_rst_in = 1'b1;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_reset();
		t_rx();
		t_ovr();
		t_abort();
		t_clksel();
		t_tx();
		wrap_up();
	end
endmodule // testbench

// *** tb/uss_master_model.sv ***
// Behavioural synchronous master that clocks the slave link
`timescale 1ns/1ps

module uss_master_model (
	// Link pins seen from the master
	output logic      link_clk_out,
	output logic      data_out,
	input  wire logic data_in
);
	// Clock rests low between frames, line starts high
	initial begin
		link_clk_out = 1'b0;
		data_out     = 1'b1;
	end

	// One frame of n bits, LSB first, ninth bit last
	// Own bit is set up well before the rise; slave bit is taken just before the fall
	task automatic frame(input logic [8:0] tx, input int n, output logic [8:0] rx);
		rx = '0;
		// Keep every link change clear of the system clock's rising edge
		#5;
		for (int i = 0; i < n; i++) begin
			#40 data_out = tx[i];
			#40 link_clk_out = 1'b1;
			#80 rx[i] = data_in;
			link_clk_out = 1'b0;
		end
		// Released line must not keep showing the last bit
		#40 data_out = ~data_out;
	endtask
endmodule // uss_master_model

// *** verilog/uss_pkg.sv ***
// Types shared by the synchronous slave serial port
package uss_pkg;
	// One register bus request
	typedef struct packed {
		logic       wr;    // Write strobe
		logic       rd;    // Read strobe
		logic [7:0] addr;  // Byte address
		logic [7:0] wdata; // Write data
	} uss_bus_req_type;

	// Transmit shifter states
	typedef enum logic [1:0] {
		USS_TX_IDLE  = 2'b01,
		USS_TX_SHIFT = 2'b10
	} uss_tx_state_type;
endpackage

// *** verilog/uss_regs.svh ***
// Register offsets, field positions and reset values of the synchronous slave serial port
//
// Contract
// [R1] Clock select cleared: slave, external shift clock
// [R2] Shifting runs from external clock during sleep; the code samples the link clock on clk_in, so shifting needs the system clock
// [R3] Two words: one shifts, one waits, flag clear
// [R4] Shift done: reload buffered word, set flag
// [R5] Software sets up transmit in listed order
// [R6] Buffer loaded before enable starts sooner
// [R7] Same as master; single receive bit ignored
// [R8] Word received moves to buffer, sets flag
// [R9] Software sets up receive in listed order
// [R10] Ninth bit and errors readable before data
// [R11] Clearing continuous receive clears latched error
// [R12] Clearing enables aborts and resets receive logic
// [R13] Data pin one bit per edge, LSB first
`ifndef USS_REGS_SVH
`define USS_REGS_SVH

// Register offsets
`define USS_OFF_TXCTL    8'h00
`define USS_OFF_RXCTL    8'h04
`define USS_OFF_TXBUF    8'h08
`define USS_OFF_RXBUF    8'h0C
`define USS_OFF_STAT     8'h10
`define USS_OFF_MASK     8'h14

// Transmit status/control fields
`define USS_B_CLK_SRC_SEL 7
`define USS_B_TX_NINE     6
`define USS_B_TX_EN       5
`define USS_B_SYNC        4
`define USS_B_TSR_EMPTY   2
`define USS_B_TXBUF_EMPTY 1
`define USS_B_TX_NINTH    0

// Receive status/control fields
`define USS_B_PORT_EN     7
`define USS_B_RX_NINE     6
`define USS_B_SINGLE_RX   5
`define USS_B_CONT_RX     4
`define USS_B_OVERRUN     1
`define USS_B_RX_NINTH    0

// Interrupt status/mask fields
`define USS_B_IRQ_TX      0
`define USS_B_IRQ_RX      1

// Reset values
`define USS_TXCTL_RST    8'h00
`define USS_RXCTL_RST    8'h00
`define USS_IRQ_RST      2'h0

`endif

// *** verilog/uss_top.sv ***
// Synchronous slave serial transmitter/receiver with register port and interrupt
`timescale 1ns/1ps
`include "uss_regs.svh"

module uss_top (
	// Clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     sys_rst_in,
	// Register port
	input  wire uss_pkg::uss_bus_req_type bus_req_in,
	output logic [7:0]                    bus_rdata_out,
	// Link pins
	input  wire logic                     link_clk_in,
	input  wire logic                     link_data_in,
	output logic                          link_data_out,
	output logic                          link_data_oe_out,
	// Interrupt
	output logic                          irq_out
);
	import uss_pkg::*;

	// Word length in bits for the nine-bit option
	function automatic logic [3:0] uss_nbits(input logic nine);
		return nine ? 4'h9 : 4'h8;
	endfunction

	// Address match against one register offset
	function automatic logic uss_hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Control registers
	logic [7:0]       txctl_q;       // Transmit control, software owned bits
	logic [7:0]       rxctl_q;       // Receive control, software owned bits
	logic [1:0]       stat_q;        // Sticky event bits
	logic [1:0]       mask_q;        // Interrupt mask
	logic [7:0]       rdata_q;       // Read data, one cycle after strobe
	logic             irq_q;         // Interrupt level
	// Transmit path
	logic [8:0]       txbuf_q;       // Holding buffer with ninth bit
	logic             txbuf_full_q;  // Holding buffer occupied
	logic [8:0]       tsr_q;         // Transmit shift register
	logic [3:0]       tcnt_q;        // Bits already sent
	uss_tx_state_type tst_q;         // Shifter state
	logic             dout_q;        // Data pin output
	logic             doe_q;         // Data pin enable
	// Receive path
	logic [8:0]       rsr_q;         // Receive shift register
	logic [3:0]       rcnt_q;        // Bits already taken
	logic [8:0]       rxbuf_q;       // Receive buffer with ninth bit
	logic             rx_err_q;      // Overrun error latch
	// Pin synchronisers
	logic             lk_s1_q;       // Link clock, first stage
	logic             lk_s2_q;       // Link clock, second stage
	logic             lk_s3_q;       // Link clock, edge history
	logic             ld_s1_q;       // Link data, first stage
	logic             ld_s2_q;       // Link data, second stage

	// Decoded controls
	logic             slave_base;    // Port on, sync mode, external clock
	logic             tx_run;        // Transmitter may shift
	logic             rx_run;        // Receiver may shift
	logic             lk_rise;       // Rising edge of link clock
	logic             lk_fall;       // Falling edge of link clock
	logic             wr_txbuf;      // Software writes holding buffer
	logic             rd_rxbuf;      // Software reads receive buffer
	logic             tx_load;       // Holding buffer moves to shifter
	logic             tx_done;       // Last bit of a word sent
	logic             rx_done;       // Last bit of a word taken
	logic [8:0]       rx_word;       // Word including the bit on the pin
	logic [1:0]       stat_set;      // Hardware events this cycle
	logic [1:0]       stat_clr;      // Clears this cycle
	logic [3:0]       tx_bits;       // Transmit word length
	logic [3:0]       rx_bits;       // Receive word length

	// Mode decode; only a cleared clock select gives slave operation
	assign slave_base = rxctl_q[`USS_B_PORT_EN] & txctl_q[`USS_B_SYNC]
		& ~txctl_q[`USS_B_CLK_SRC_SEL]; // [R1]
	// Receive wins the shared data pin; the single receive bit is never looked at
	assign rx_run  = slave_base & rxctl_q[`USS_B_CONT_RX]; // [R7]
	assign tx_run  = slave_base & txctl_q[`USS_B_TX_EN] & ~rxctl_q[`USS_B_CONT_RX];
	assign lk_rise = lk_s2_q & ~lk_s3_q;
	assign lk_fall = ~lk_s2_q & lk_s3_q;
	assign tx_bits = uss_nbits(txctl_q[`USS_B_TX_NINE]);
	assign rx_bits = uss_nbits(rxctl_q[`USS_B_RX_NINE]);
	assign wr_txbuf = bus_req_in.wr & uss_hit(bus_req_in.addr, `USS_OFF_TXBUF);
	assign rd_rxbuf = bus_req_in.rd & uss_hit(bus_req_in.addr, `USS_OFF_RXBUF);
	// A word waiting at enable time starts at once, without a new write
	assign tx_load = tx_run & (tst_q == USS_TX_IDLE) & txbuf_full_q; // [R6]
	assign tx_done = (tst_q == USS_TX_SHIFT) & lk_fall & (tcnt_q == tx_bits - 4'h1);
	assign rx_done = rx_run & lk_rise & (rcnt_q == rx_bits - 4'h1);

	// Link synchronisers; only the second stages and the clock edge history feed logic
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			lk_s1_q <= 1'b0;
			lk_s2_q <= 1'b0;
			lk_s3_q <= 1'b0;
			ld_s1_q <= 1'b0;
			ld_s2_q <= 1'b0;
		end else begin
			lk_s1_q <= link_clk_in;
			lk_s2_q <= lk_s1_q;
			lk_s3_q <= lk_s2_q;
			ld_s1_q <= link_data_in;
			ld_s2_q <= ld_s1_q;
		end
	end

	// Control registers; status and read-only bits are not stored here
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			txctl_q <= `USS_TXCTL_RST;
			rxctl_q <= `USS_RXCTL_RST;
			mask_q  <= `USS_IRQ_RST;
		end else if (bus_req_in.wr) begin
			if (uss_hit(bus_req_in.addr, `USS_OFF_TXCTL)) begin
				txctl_q <= bus_req_in.wdata & 8'hF1;
			end
			if (uss_hit(bus_req_in.addr, `USS_OFF_RXCTL)) begin
				rxctl_q <= bus_req_in.wdata & 8'hF0;
			end
			if (uss_hit(bus_req_in.addr, `USS_OFF_MASK)) begin
				mask_q <= bus_req_in.wdata[1:0];
			end
		end
	end

	// Holding buffer; the ninth bit is captured with the data
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			txbuf_q      <= 9'h000;
			txbuf_full_q <= 1'b0;
		end else if (wr_txbuf) begin
			// A write while full replaces the waiting word
			txbuf_q      <= {txctl_q[`USS_B_TX_NINTH], bus_req_in.wdata};
			txbuf_full_q <= 1'b1;
		end else if (tx_load) begin
			txbuf_full_q <= 1'b0;
		end
	end

	// Transmit shifter; bits change on the master's falling edge
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			tst_q  <= USS_TX_IDLE;
			tsr_q  <= 9'h000;
			tcnt_q <= 4'h0;
		end else if (!tx_run) begin
			// Disabling drops a half-sent word
			tst_q  <= USS_TX_IDLE;
			tcnt_q <= 4'h0;
		end else begin
			unique case (tst_q)
				USS_TX_IDLE: begin
					if (tx_load) begin // [R3] [R4]
						tsr_q  <= txbuf_q;
						tcnt_q <= 4'h0;
						tst_q  <= USS_TX_SHIFT;
					end
				end
				USS_TX_SHIFT: begin
					// Bits move on clk_in once the synchronised link clock falls; both clocks must run
					if (tx_done) begin // [R2]
						tst_q <= USS_TX_IDLE;
					end else if (lk_fall) begin // [R13]
						tsr_q  <= {1'b0, tsr_q[8:1]};
						tcnt_q <= tcnt_q + 4'h1;
					end
				end
			endcase
		end
	end

	// Data pin drive; high idle level when no word is in the shifter
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			dout_q <= 1'b1;
			doe_q  <= 1'b0;
		end else begin
			dout_q <= (tst_q == USS_TX_SHIFT) ? tsr_q[0] : 1'b1; // [R13]
			doe_q  <= tx_run; // [R1]
		end
	end

	// Word as it stands once the current pin bit is added
	always_comb begin
		rx_word = rsr_q;
		rx_word[rcnt_q] = ld_s2_q;
		if (!rxctl_q[`USS_B_RX_NINE]) begin
			rx_word[8] = 1'b0;
		end
	end

	// Receive shifter; sampled on the master's rising edge, LSB first
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rsr_q  <= 9'h000;
			rcnt_q <= 4'h0;
		end else if (!rx_run) begin
			rcnt_q <= 4'h0; // [R12]
		end else if (lk_rise) begin // [R2] [R13]
			rsr_q[rcnt_q] <= ld_s2_q;
			rcnt_q <= rx_done ? 4'h0 : rcnt_q + 4'h1;
		end
	end

	// Receive buffer and overrun latch; the buffered word is not overwritten while the receive flag is set
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rxbuf_q  <= 9'h000;
			rx_err_q <= 1'b0;
		end else begin
			if (rx_done && !stat_q[`USS_B_IRQ_RX]) begin
				rxbuf_q <= rx_word; // [R8]
			end
			if (!rxctl_q[`USS_B_CONT_RX]) begin
				rx_err_q <= 1'b0; // [R11]
			end else if (rx_done && stat_q[`USS_B_IRQ_RX]) begin
				rx_err_q <= 1'b1;
			end
		end
	end

	// Sticky events; set beats clear in the same cycle
	always_comb begin
		stat_set = 2'b00;
		stat_set[`USS_B_IRQ_TX] = tx_load & ~wr_txbuf; // [R3] [R4]
		stat_set[`USS_B_IRQ_RX] = rx_done; // [R8]
		stat_clr = 2'b00;
		if (bus_req_in.wr && uss_hit(bus_req_in.addr, `USS_OFF_STAT)) begin
			stat_clr = bus_req_in.wdata[1:0];
		end
		stat_clr[`USS_B_IRQ_TX] = stat_clr[`USS_B_IRQ_TX] | wr_txbuf;
		stat_clr[`USS_B_IRQ_RX] = stat_clr[`USS_B_IRQ_RX] | rd_rxbuf;
	end

	// Status register and interrupt level; the level doubles as the wake request
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			stat_q <= `USS_IRQ_RST;
			irq_q  <= 1'b0;
		end else begin
			stat_q <= (stat_q & ~stat_clr) | stat_set;
			irq_q  <= |(stat_q & mask_q); // [R4] [R8]
		end
	end

	// Read mux; unmapped addresses and idle cycles return zero
	always_ff @(posedge clk_in) begin
		if (sys_rst_in) begin
			rdata_q <= 8'h00;
		end else if (!bus_req_in.rd) begin
			rdata_q <= 8'h00;
		end else begin
			unique case (bus_req_in.addr)
				`USS_OFF_TXCTL: rdata_q <= txctl_q | {5'h00, (tst_q == USS_TX_IDLE),
					~txbuf_full_q, 1'b0};
				// Ninth bit and error are visible before the data is read
				`USS_OFF_RXCTL: rdata_q <= rxctl_q | {6'h00, rx_err_q, rxbuf_q[8]}; // [R10]
				`USS_OFF_RXBUF: rdata_q <= rxbuf_q[7:0];
				`USS_OFF_STAT:  rdata_q <= {6'h00, stat_q};
				`USS_OFF_MASK:  rdata_q <= {6'h00, mask_q};
				default:        rdata_q <= 8'h00;
			endcase
		end
	end

	assign bus_rdata_out    = rdata_q;
	assign link_data_out    = dout_q;
	assign link_data_oe_out = doe_q;
	assign irq_out          = irq_q;

	// Checks
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (sys_rst_in);

	// Last bit out with a word waiting and no software write racing it
	sequence s_last_bit_with_wait;
		tx_done && txbuf_full_q && tx_run && !wr_txbuf;
	endsequence
	sequence s_reload;
		(tst_q == USS_TX_IDLE) ##1 (tst_q == USS_TX_SHIFT) && stat_q[`USS_B_IRQ_TX];
	endsequence

	AST_MASTER_NO_DRIVE: assert property ( // [R1]
		txctl_q[`USS_B_CLK_SRC_SEL] |=> !link_data_oe_out)
		else $error("data pin driven with internal clock selected");
	AST_RX_EDGE_COUNTS: assert property ( // [R2]
		(rx_run && lk_rise && rcnt_q == 4'h0) |=> rcnt_q == 4'h1)
		else $error("link clock edge did not advance receiver");
	AST_SECOND_WORD_WAITS: assert property ( // [R3]
		(wr_txbuf && tst_q == USS_TX_SHIFT && tx_run && !tx_done)
		|=> txbuf_full_q && !stat_q[`USS_B_IRQ_TX])
		else $error("second word not held or flag set");
	AST_RELOAD_SETS_FLAG: assert property ( // [R4]
		s_last_bit_with_wait |=> s_reload)
		else $error("buffered word not reloaded with flag");
	AST_RX_TO_BUFFER: assert property ( // [R8]
		(rx_done && !stat_q[`USS_B_IRQ_RX])
		|=> rxbuf_q == $past(rx_word) && stat_q[`USS_B_IRQ_RX])
		else $error("received word not moved to buffer");
	AST_NINTH_VISIBLE: assert property ( // [R10]
		(bus_req_in.rd && bus_req_in.addr == `USS_OFF_RXCTL)
		|=> bus_rdata_out[`USS_B_RX_NINTH] == $past(rxbuf_q[8]))
		else $error("ninth bit not readable in receive status");
	AST_ERR_CLEARED: assert property ( // [R11]
		!rxctl_q[`USS_B_CONT_RX] |=> !rx_err_q)
		else $error("error survived receive disable");
	AST_ABORT_RESETS: assert property ( // [R12]
		!rxctl_q[`USS_B_PORT_EN] |=> rcnt_q == 4'h0 && tst_q == USS_TX_IDLE)
		else $error("port disable did not reset shifters");
	AST_IRQ_LEVEL: assert property ( // [R8]
		|(stat_q & mask_q) |=> irq_out)
		else $error("interrupt not raised for unmasked event");
	AST_IRQ_QUIET: assert property ( // [R4]
		!(|(stat_q & mask_q)) |=> !irq_out)
		else $error("interrupt raised with no unmasked event");
	AST_TX_LSB_FIRST: assert property ( // [R13]
		(tst_q == USS_TX_SHIFT && tx_run) |=> link_data_out == $past(tsr_q[0]))
		else $error("data pin does not carry shifter bit");

endmodule // uss_top
